// ### hdl/rebsi_builder.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module rebsi_builder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rebsi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic blk_avail,
  input wire logic [rebsi_pkg::LEN_W-1:0] trig_len,
  input wire logic [rebsi_pkg::LEN_W-1:0] logic_len,
  input wire logic [31:0] evt_data,
  output logic evt_take,
  output logic blk_ack,
  rebsi_link_if.builder lnk
);
  import rebsi_pkg::*;
  rebsi_main_type main;
  rebsi_rec_type rec;
  rebsi_xfer_type xfer;
  rebsi_trig_type trig;
  logic [31:0] ctrl, net_data, cur_word, rd_mux;
  logic [31:0] fifo_mem [0:FIFO_FULL_COUNT-1];
  logic [FIFO_AW-1:0] wr_ptr, rd_ptr;
  logic [COUNT_W-1:0] fcount;
  logic [LEN_W-1:0] len_mem [0:LEN_FULL_COUNT-1];
  logic [LEN_AW-1:0] len_wp, len_rp;
  logic [2:0] len_cnt;
  logic [15:0] pending, word_cnt, block_num;
  logic [LEN_W-1:0] ti_len_q, tl_len_q, cpu_len_q;
  logic trig_body, net_valid, have_word, ext, last, mapped;
  assign lnk.word_valid = net_valid;
  assign lnk.word_data = net_data;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire wr_ctrl = apb_wr & (paddr == CTRL_OFFSET);
  wire wr_data = apb_wr & (paddr == DATA_OFFSET);
  wire wr_len = apb_wr & (paddr == LEN_OFFSET);
  wire sync_en = ctrl[SYNC_EN_BIT];
  wire fifo_full = (fcount == FIFO_FULL_COUNT);
  wire out_free = ~net_valid | ~lnk.engine_full;
  wire step = out_free & have_word;
  wire [15:0] rec_len = REC_HDR_WORDS + TRIG_HDR_WORDS + ti_len_q + tl_len_q + cpu_len_q;
  wire [15:0] total_len = XFER_WORDS + 16'h1 + rec_len;
  wire blk_start = (main == M_IDLE) & blk_avail & ~blk_ack;
  wire len_pop = (main == M_GET_SYNC_LEN) & sync_en & (len_cnt != 3'h0);
  wire fifo_push = wr_data & ~fifo_full;
  wire fifo_pop = step & (main == M_SYNC_DATA);
  wire len_push = wr_len & (len_cnt != LEN_FULL_COUNT);
  wire [31:0] status_word = {15'h0, lnk.engine_full, main, rec, xfer, trig};
  // register read selection
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    if (paddr == CTRL_OFFSET) rd_mux = ctrl;
    else if (paddr == STATUS_OFFSET) rd_mux = status_word;
    else if (paddr == PENDING_OFFSET) rd_mux = {16'h0, pending};
    else if (paddr == FIFO_STAT_OFFSET) rd_mux = {fifo_full, 21'h0, fcount};
    else if (paddr != DATA_OFFSET && paddr != LEN_OFFSET) mapped = 1'b0;
  end
  // word to emit in the current phase
  always_comb begin
    have_word = 1'b0;
    ext = 1'b0;
    last = 1'b0;
    cur_word = 32'h0;
    case (main)
      M_XFER_HDR: begin
        have_word = 1'b1;
        last = (xfer == X_RES2);
        case (xfer)
          X_MSG: cur_word = {MSG_TYPE, total_len};
          X_BLOCK: cur_word = {total_len, block_num};
          X_HDR_LEN: cur_word = {HDR_TAG, rec_len};
          default: cur_word = 32'h0;
        endcase
      end
      M_REC_HDR: begin
        have_word = 1'b1;
        case (rec)
          R_REC_LEN: cur_word = {16'h0, rec_len};
          R_STATUS_ID: cur_word = {STATUS_BYTE, 16'h0, READER_ID};
          R_BANK_LEN: cur_word = {16'h0, ti_len_q + TRIG_HDR_WORDS};
          default: begin
            if (trig_body) begin
              have_word = ~evt_take;
              ext = 1'b1;
              cur_word = evt_data;
              last = (word_cnt + 16'h1 == ti_len_q);
            end else begin
              last = (trig == T_RES2) & (ti_len_q == 16'h0);
              case (trig)
                T_BLOCK: cur_word = {ti_len_q, block_num};
                T_HDR_LEN: cur_word = {HDR_TAG, ti_len_q};
                default: cur_word = 32'h0;
              endcase
            end
          end
        endcase
      end
      M_LOGIC_DATA: begin
        have_word = ~evt_take & (tl_len_q != 16'h0);
        ext = 1'b1;
        cur_word = evt_data;
        last = (word_cnt + 16'h1 == tl_len_q);
      end
      M_SYNC_DATA: begin
        have_word = (fcount != 10'h0) & (cpu_len_q != 16'h0);
        cur_word = fifo_mem[rd_ptr];
        last = (word_cnt + 16'h1 == cpu_len_q);
      end
      default: begin
        have_word = 1'b0;
      end
    endcase
  end
  // bus slave: no wait states, answer in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl <= CTRL_RESET;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      if (apb_setup) prdata <= rd_mux;
      if (wr_ctrl) ctrl <= pwdata;
    end
  end
  // processor data and length queues, filled in any order
  always_ff @(posedge ref_clk) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr] <= pwdata;
    end
    if (len_push) begin
      len_mem[len_wp] <= pwdata[LEN_W-1:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fcount <= '0;
      len_wp <= '0;
      len_rp <= '0;
      len_cnt <= 3'h0;
      pending <= 16'h0;
    end else begin
      if (fifo_push) wr_ptr <= wr_ptr + 9'h1;
      if (fifo_pop) rd_ptr <= rd_ptr + 9'h1;
      if (fifo_push & ~fifo_pop) fcount <= fcount + 10'h1;
      else if (fifo_pop & ~fifo_push) fcount <= fcount - 10'h1;
      if (len_push) len_wp <= len_wp + 2'h1;
      if (len_pop) len_rp <= len_rp + 2'h1;
      if (len_push & ~len_pop) len_cnt <= len_cnt + 3'h1;
      else if (len_pop & ~len_push) len_cnt <= len_cnt - 3'h1;
      if (blk_start & ~wr_len) pending <= pending + 16'h1;
      else if (wr_len & ~blk_start) pending <= pending - 16'h1;
    end
  end
  // output word register, held while the engine is full
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      net_valid <= 1'b0;
      net_data <= 32'h0;
      evt_take <= 1'b0;
      blk_ack <= 1'b0;
    end else begin
      if (out_free) net_valid <= step;
      if (step) net_data <= cur_word;
      evt_take <= step & ext;
      blk_ack <= (main == M_ACK);
    end
  end
  // main sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main <= M_IDLE;
      rec <= R_REC_LEN;
      xfer <= X_MSG;
      trig <= T_BLOCK;
      trig_body <= 1'b0;
      word_cnt <= 16'h0;
      block_num <= 16'h0;
      ti_len_q <= 16'h0;
      tl_len_q <= 16'h0;
      cpu_len_q <= 16'h0;
    end else begin
      case (main)
        M_IDLE: if (blk_start) main <= M_GET_TRIG_LEN;
        M_GET_TRIG_LEN: begin
          ti_len_q <= trig_len;
          main <= M_GET_LOGIC_LEN;
        end
        M_GET_LOGIC_LEN: begin
          tl_len_q <= logic_len;
          main <= M_GET_SYNC_LEN;
        end
        M_GET_SYNC_LEN: begin
          if (!sync_en) begin
            cpu_len_q <= 16'h0;
            main <= M_XFER_HDR;
          end else if (len_pop) begin
            cpu_len_q <= len_mem[len_rp];
            main <= M_XFER_HDR;
          end
        end
        M_XFER_HDR: begin
          if (step) begin
            if (last) begin
              xfer <= X_MSG;
              main <= M_REC_HDR;
            end else begin
              xfer <= rebsi_xfer_type'(xfer + 4'h1);
            end
          end
        end
        M_REC_HDR: begin
          if (step) begin
            if (rec != R_TRIG_DATA) begin
              rec <= rebsi_rec_type'(rec + 4'h1);
            end else if (last) begin
              rec <= R_REC_LEN;
              trig <= T_BLOCK;
              trig_body <= 1'b0;
              word_cnt <= 16'h0;
              main <= M_LOGIC_DATA;
            end else if (trig_body) begin
              word_cnt <= word_cnt + 16'h1;
            end else if (trig == T_RES2) begin
              trig <= T_BLOCK;
              trig_body <= 1'b1;
            end else begin
              trig <= rebsi_trig_type'(trig + 4'h1);
            end
          end
        end
        M_LOGIC_DATA: begin
          if (tl_len_q == 16'h0) begin
            main <= M_SYNC_DATA;
          end else if (step) begin
            word_cnt <= last ? 16'h0 : word_cnt + 16'h1;
            if (last) main <= M_SYNC_DATA;
          end
        end
        M_SYNC_DATA: begin
          if (cpu_len_q == 16'h0) begin
            main <= M_ASYNC_DATA;
          end else if (step) begin
            word_cnt <= last ? 16'h0 : word_cnt + 16'h1;
            if (last) main <= M_ASYNC_DATA;
          end
        end
        M_ASYNC_DATA: main <= M_ACK;
        default: begin
          block_num <= block_num + 16'h1;
          main <= M_IDLE;
        end
      endcase
    end
  end
endmodule

// ### hdl/rebsi_pkg.sv
// Summary of operation
// - status bit 16 shows network engine full
// - main state 0 idle, 1-3 length reads
// - main state 4-8 write phases, then acknowledge 9
// - record header sub-state encodes 0 to 3
// - transfer header sub-state encodes 0 to 4
// - trigger data sub-state encodes 0 to 3
// - data register write pushes sync FIFO word
// - software must never overflow 512-word FIFO
// - long events: write length, poll full, write
// - fifo status bit 31 shows FIFO full
// - fifo status bits 9:0 show word count
// - length write marks event data ready
// - zero length means no processor words
// - software writes one length per block
// - data and length accepted in either order
// - enable bit 9 requires processor sync bank
// - pending count: block increments, length decrements
package rebsi_pkg;
  localparam int ADDR_W = 8;
  localparam int LEN_W = 16;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] PENDING_OFFSET = 8'h0c;
  localparam logic [7:0] DATA_OFFSET = 8'h10;
  localparam logic [7:0] FIFO_STAT_OFFSET = 8'h14;
  localparam logic [7:0] LEN_OFFSET = 8'h18;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam int SYNC_EN_BIT = 9;
  localparam int NET_FULL_BIT = 16;
  localparam int FIFO_FULL_BIT = 31;
  localparam int FIFO_AW = 9;
  localparam int COUNT_W = 10;
  localparam logic [9:0] FIFO_FULL_COUNT = 10'h200;
  localparam int LEN_AW = 2;
  localparam logic [2:0] LEN_FULL_COUNT = 3'h4;
  localparam logic [15:0] MSG_TYPE = 16'h0001;
  localparam logic [15:0] HDR_TAG = 16'h1000;
  localparam logic [7:0] READER_ID = 8'h01; // arbitrary value
  localparam logic [7:0] STATUS_BYTE = 8'h00;
  localparam logic [15:0] XFER_WORDS = 16'h0005;
  localparam logic [15:0] TRIG_HDR_WORDS = 16'h0004;
  localparam logic [15:0] REC_HDR_WORDS = 16'h0003;
  typedef enum logic [3:0] {
    M_IDLE, M_GET_TRIG_LEN, M_GET_LOGIC_LEN, M_GET_SYNC_LEN, M_XFER_HDR,
    M_REC_HDR, M_LOGIC_DATA, M_SYNC_DATA, M_ASYNC_DATA, M_ACK
  } rebsi_main_type;
  typedef enum logic [3:0] {R_REC_LEN, R_STATUS_ID, R_BANK_LEN, R_TRIG_DATA} rebsi_rec_type;
  typedef enum logic [3:0] {X_MSG, X_BLOCK, X_HDR_LEN, X_RES1, X_RES2} rebsi_xfer_type;
  typedef enum logic [3:0] {T_BLOCK, T_HDR_LEN, T_RES1, T_RES2} rebsi_trig_type;
endpackage

// ### hdl/rebsi_link_if.sv
`timescale 1ns/100ps
interface rebsi_link_if;
  logic [31:0] word_data;
  logic word_valid;
  logic engine_full;
  modport builder (output word_data, output word_valid, input engine_full);
  modport engine (input word_data, input word_valid, output engine_full);
endinterface

// ### hdl/rebsi_net_engine.sv
`timescale 1ns/100ps
module rebsi_net_engine (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_up,
  input wire logic stall_req,
  output logic [31:0] rx_data,
  output logic rx_strobe,
  output logic [31:0] rx_count,
  rebsi_link_if.engine lnk
);
  import rebsi_pkg::*;
  logic full;
  wire taken = lnk.word_valid & ~full;
  assign lnk.engine_full = full;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      full <= 1'b1;
      rx_data <= 32'h0;
      rx_strobe <= 1'b0;
      rx_count <= 32'h0;
    end else begin
      full <= stall_req | ~link_up;
      rx_strobe <= taken;
      if (taken) begin
        rx_data <= lnk.word_data;
        rx_count <= rx_count + 32'h1;
      end
    end
  end
endmodule

// ### sim/rebsi_assertions.sv
`timescale 1ns/100ps
module rebsi_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] word_data,
  input wire logic word_valid,
  input wire logic engine_full,
  input wire logic link_up,
  input wire logic stall_req,
  input wire logic blk_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_stall_keeps_valid: assert property (
    word_valid && engine_full |=> word_valid) else $error("word dropped while engine full");
  a_stall_keeps_data: assert property (
    word_valid && engine_full |=> $stable(word_data)) else $error("word changed while stalled");
  a_reset_link_idle: assert property (disable iff (1'b0)
    rst |=> !word_valid && word_data == 32'h0) else $error("link active during reset");
  a_reset_engine_full: assert property (disable iff (1'b0)
    rst |=> engine_full) else $error("engine ready during reset");
  a_full_on_cause: assert property (
    stall_req || !link_up |=> engine_full) else $error("engine not full on stall or link down");
  a_free_when_ready: assert property (
    !stall_req && link_up |=> !engine_full) else $error("engine full with link up and no stall");
  a_ack_single_pulse: assert property (
    blk_ack |=> !blk_ack) else $error("block acknowledge longer than one cycle");
  c_stall: cover property (word_valid && engine_full);
  c_taken: cover property (word_valid && !engine_full);
  c_resume: cover property ($fell(engine_full) && word_valid);
endmodule

// ### sim/tb_rebsi.sv
`timescale 1ns/100ps
module tb_rebsi;
  import rebsi_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, blk_avail = 1'b0;
  logic link_up = 1'b1, stall_req = 1'b0, stall_on = 1'b0;
  logic pready, pslverr, evt_take, blk_ack, rx_strobe, er;
  logic [7:0] paddr = 8'h00;
  logic [15:0] trig_len = 16'h0, logic_len = 16'h0;
  logic [31:0] pwdata = 32'h0, evt_data = 32'h100;
  logic [31:0] prdata, rx_data, rx_count, r, e0;
  logic [31:0] q[$], x[$], m[$];
  logic [8:0] tab [7] = '{{1'b0, CTRL_OFFSET}, {1'b0, STATUS_OFFSET}, {1'b0, PENDING_OFFSET},
    {1'b0, DATA_OFFSET}, {1'b0, FIFO_STAT_OFFSET}, {1'b0, LEN_OFFSET}, {1'b1, 8'h40}};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  rebsi_link_if lnk ();
  rebsi_builder rebsi_builder_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .blk_avail(blk_avail), .trig_len(trig_len),
    .logic_len(logic_len), .evt_data(evt_data), .evt_take(evt_take), .blk_ack(blk_ack),
    .lnk(lnk));
  rebsi_net_engine rebsi_net_engine_inst (.ref_clk(ref_clk), .rst(rst), .link_up(link_up),
    .stall_req(stall_req), .rx_data(rx_data), .rx_strobe(rx_strobe), .rx_count(rx_count),
    .lnk(lnk));
  rebsi_assertions rebsi_assertions_inst (.ref_clk(ref_clk), .rst(rst),
    .word_data(lnk.word_data), .word_valid(lnk.word_valid), .engine_full(lnk.engine_full),
    .link_up(link_up), .stall_req(stall_req), .blk_ack(blk_ack));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task test_done();
    $display("mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    stall_req <= stall_on & cyc[2];
    if (evt_take === 1'b1) evt_data <= evt_data + 32'h1;
    if (rx_strobe === 1'b1) q.push_back(rx_data);
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    logic te;
    apb(1'b1, a, d, t, te);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    logic te;
    apb(1'b0, a, 32'h0, t, te);
    check(t, exp);
  endtask
  task fill(input int n, input logic [31:0] b);
    for (int i = 0; i < n; i++) wr(DATA_OFFSET, b + i);
  endtask
  task start(input int ti, input int tl);
    trig_len <= ti[15:0];
    logic_len <= tl[15:0];
    blk_avail <= 1'b1;
    q = {};
    e0 = evt_data;
  endtask
  task fin();
    @(posedge ref_clk iff blk_ack === 1'b1);
    blk_avail <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task p(input logic [31:0] d, input logic [31:0] mk);
    x.push_back(d);
    m.push_back(mk);
  endtask
  // build the expected block word by word
  task blk_chk(input int ti, input int tl, input int cpu, input logic [31:0] s0,
    input logic [15:0] bn);
    logic [31:0] rl;
    logic [15:0] tot;
    rl = 32'(7 + ti + tl + cpu);
    tot = 16'(6 + rl);
    x = {};
    m = {};
    p({MSG_TYPE, tot}, '1);
    p({tot, bn}, '1);
    p({HDR_TAG, rl[15:0]}, '1);
    p(32'h0, '1);
    p(32'h0, '1);
    p(rl, '1);
    p({STATUS_BYTE, 16'h0, READER_ID}, '1);
    p(32'(ti + 4), '1);
    p({ti[15:0], bn}, '1);
    p({HDR_TAG, ti[15:0]}, '1);
    p(32'h0, '1);
    p(32'h0, '1);
    for (int i = 0; i < ti + tl; i++) p(e0 + i, '1);
    for (int i = 0; i < cpu; i++) p(s0 + i, '1);
    check(q.size(), x.size());
    foreach (x[i]) check(q[i] & m[i], x[i] & m[i]);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (tab[i]) begin
      apb(1'b0, tab[i][7:0], 32'h0, r, er);
      check(r, 32'h0);
      check({31'h0, er}, {31'h0, tab[i][8]});
    end
    link_up <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(STATUS_OFFSET, 32'h00010000);
    link_up <= 1'b1;
    wr(CTRL_OFFSET, 32'h00000200);
    start(2, 1);
    repeat (10) @(posedge ref_clk);
    rd(STATUS_OFFSET, 32'h00003000);
    rd(PENDING_OFFSET, 32'h1);
    fill(3, 32'h5000);
    stall_on <= 1'b1;
    wr(LEN_OFFSET, 32'h3);
    fin();
    blk_chk(2, 1, 3, 32'h5000, 16'h0);
    stall_on <= 1'b0;
    rd(PENDING_OFFSET, 32'h0);
    wr(LEN_OFFSET, 32'h0);
    rd(PENDING_OFFSET, 32'h0000ffff);
    start(0, 0);
    fin();
    blk_chk(0, 0, 0, 32'h0, 16'h1);
    rd(PENDING_OFFSET, 32'h0);
    wr(LEN_OFFSET, 32'h202);
    fill(512, 32'h7000);
    rd(FIFO_STAT_OFFSET, 32'h80000200);
    start(1, 0);
    for (int i = 512; i < 514; i++) begin
      r = 32'h80000000;
      while (r[31]) apb(1'b0, FIFO_STAT_OFFSET, 32'h0, r, er);
      wr(DATA_OFFSET, 32'h7000 + i);
    end
    fin();
    blk_chk(1, 0, 514, 32'h7000, 16'h2);
    rd(FIFO_STAT_OFFSET, 32'h0);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTRL_OFFSET, CTRL_RESET);
    rd(STATUS_OFFSET, 32'h0);
    start(1, 1);
    fin();
    blk_chk(1, 1, 0, 32'h0, 16'h0);
    rd(PENDING_OFFSET, 32'h1);
    check(rx_count, 32'h0000000e);
    test_done();
  end
endmodule
